// File: rtl/gmo_map.vh
// Constants for the graphics memory organization register block.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
// Operation
// - All buffers live inside a 4 MB aperture based at the memory controller field.
// - Frame, compressed and cursor buffers each have a programmable aperture offset.
// - Cursor data is one linear block from its offset, no line stride.
// - Frame and compressed buffers walk by line: DWORD count, next line adds delta.
// - Six 32-bit registers occupy offsets 8310h through 8328h.
// - Frame start bits 21:0 are a byte offset; bits 31:22 reserved, zero.
// - Nonzero frame start memory bits 21:4 take effect at next frame start.
// - Frame start pixel bits 3:0 take effect at once on write.
`ifndef GMO_MAP_VH
`define GMO_MAP_VH
`define GMO_ADR_W         16
`define GMO_FB_OFS        16'h8310
`define GMO_CB_OFS        16'h8314
`define GMO_CUR_OFS       16'h8318
`define GMO_PITCH_OFS     16'h8324
`define GMO_LINE_OFS      16'h8320
`define GMO_LOCK_OFS      16'h8328
`define GMO_OFS_W         22
`define GMO_PIX_W         4
`define GMO_LOCK_KEY      32'h00004758
`endif

// File: rtl/gmo_core.v
// Memory organization registers and display fetch address generator.
// Assumes a classic Wishbone master and a fetch engine giving frame and line strobes.
`timescale 1ns/100ps
`include "gmo_map.vh"
module gmo_core #(
   parameter OFS_W  = 22,
   parameter BASE_W = 32
) (
   SYS_CLK,
   RESETN,
   WB_CYC_I,
   WB_STB_I,
   WB_WE_I,
   WB_ADR_I,
   WB_SEL_I,
   WB_DAT_I,
   WB_DAT_O,
   WB_ACK_O,
   WB_ERR_O,
   GFX_BASE,
   FRAME_START,
   LINE_START,
   FETCH_SEL,
   FETCH_ADDR,
   FETCH_DW_MAX,
   PIXEL_OFFSET,
   LOCKED
);
   input  wire                 SYS_CLK;
   input  wire                 RESETN;
   input  wire                 WB_CYC_I;
   input  wire                 WB_STB_I;
   input  wire                 WB_WE_I;
   input  wire [15:0]          WB_ADR_I;
   input  wire [3:0]           WB_SEL_I;
   input  wire [31:0]          WB_DAT_I;
   output reg  [31:0]          WB_DAT_O;
   output reg                  WB_ACK_O;
   output reg                  WB_ERR_O;
   input  wire [BASE_W-1:0]    GFX_BASE;
   input  wire                 FRAME_START;
   input  wire                 LINE_START;
   input  wire [1:0]           FETCH_SEL;
   output reg  [BASE_W-1:0]    FETCH_ADDR;
   output reg  [11:0]          FETCH_DW_MAX;
   output reg  [3:0]           PIXEL_OFFSET;
   output reg                  LOCKED;

   localparam [1:0] SEL_FB  = 2'h0;
   localparam [1:0] SEL_CB  = 2'h1;
   localparam [1:0] SEL_CUR = 2'h2;

   reg  [OFS_W-1:0] fb_pend_q;
   reg  [OFS_W-1:0] fb_live_q;
   reg  [OFS_W-1:0] cb_q;
   reg  [OFS_W-1:0] cur_q;
   reg  [11:0]      fb_pitch_q;
   reg  [11:0]      cb_pitch_q;
   reg  [11:0]      fb_dw_q;
   reg  [11:0]      cb_dw_q;
   reg              lock_q;
   reg  [OFS_W-1:0] fb_line_q;
   reg  [OFS_W-1:0] cb_line_q;
   reg  [OFS_W-1:0] cur_ptr_q;
   reg              fb_upd_q;

   wire req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
   wire adr_ok  = (WB_ADR_I == `GMO_FB_OFS) | (WB_ADR_I == `GMO_CB_OFS) | (WB_ADR_I == `GMO_CUR_OFS) |
                  (WB_ADR_I == 16'h831C) | (WB_ADR_I == `GMO_LINE_OFS) | (WB_ADR_I == `GMO_PITCH_OFS) |
                  (WB_ADR_I == `GMO_LOCK_OFS);
   wire wr      = req & adr_ok & WB_WE_I;
   wire wr_open = wr & ~lock_q;

   // Merges byte lanes into a 32-bit old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // Address inside the aperture; offset wraps within 4 MB
   function [BASE_W-1:0] ap_addr;
      input [BASE_W-1:0] base;
      input [OFS_W-1:0]  ofs;
      begin
         ap_addr = base + {{(BASE_W-OFS_W){1'b0}}, ofs};
      end
   endfunction

   wire [31:0] fb_word  = merge({10'h000, fb_pend_q}, WB_DAT_I, WB_SEL_I);
   wire [31:0] cb_word  = merge({10'h000, cb_q}, WB_DAT_I, WB_SEL_I);
   wire [31:0] cur_word = merge({10'h000, cur_q}, WB_DAT_I, WB_SEL_I);
   wire [31:0] ln_word  = merge({4'h0, cb_dw_q, 4'h0, fb_dw_q}, WB_DAT_I, WB_SEL_I);
   wire [31:0] pt_word  = merge({4'h0, cb_pitch_q, 4'h0, fb_pitch_q}, WB_DAT_I, WB_SEL_I);
   wire [31:0] lk_word  = merge(32'h00000000, WB_DAT_I, WB_SEL_I);

   // Programmed offset, DWORD count and delta registers have no reset; live, walker, lock and output state does
   always @(posedge SYS_CLK) begin
      if (wr_open && WB_ADR_I == `GMO_FB_OFS) begin
         fb_pend_q <= fb_word[21:0];
      end
      if (wr_open && WB_ADR_I == `GMO_CB_OFS) begin
         cb_q <= cb_word[21:0];
      end
      if (wr_open && WB_ADR_I == `GMO_CUR_OFS) begin
         cur_q <= cur_word[21:0];
      end
      if (wr_open && WB_ADR_I == `GMO_LINE_OFS) begin
         fb_dw_q <= ln_word[11:0];
         cb_dw_q <= ln_word[27:16];
      end
      if (wr_open && WB_ADR_I == `GMO_PITCH_OFS) begin
         fb_pitch_q <= pt_word[11:0];
         cb_pitch_q <= pt_word[27:16];
      end
   end

   // Memory part waits for the frame; a write in that same cycle is taken next frame
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fb_upd_q  <= 1'b0;
         fb_live_q <= {OFS_W{1'b0}};
         lock_q    <= 1'b0;
      end else begin
         if (wr && WB_ADR_I == `GMO_LOCK_OFS) begin
            lock_q <= (lk_word != `GMO_LOCK_KEY);
         end
         if (wr_open && WB_ADR_I == `GMO_FB_OFS && fb_word[21:0] != 22'h000000) begin
            fb_upd_q <= 1'b1;
         end else if (FRAME_START) begin
            fb_upd_q <= 1'b0;
         end
         if (FRAME_START && fb_upd_q) begin
            fb_live_q <= {fb_pend_q[21:4], 4'h0};
         end
      end
   end

   // Line walkers: frame and compressed buffers step by delta, cursor is linear
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fb_line_q <= {OFS_W{1'b0}};
         cb_line_q <= {OFS_W{1'b0}};
         cur_ptr_q <= {OFS_W{1'b0}};
      end else if (FRAME_START) begin
         fb_line_q <= fb_upd_q ? {fb_pend_q[21:4], 4'h0} : fb_live_q;
         cb_line_q <= cb_q;
         cur_ptr_q <= cur_q;
      end else if (LINE_START) begin
         fb_line_q <= fb_line_q + {10'h000, fb_pitch_q};
         cb_line_q <= cb_line_q + {10'h000, cb_pitch_q};
      end
   end

   // Bus answer and fetch outputs, all registered
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         WB_ACK_O     <= 1'b0;
         WB_ERR_O     <= 1'b0;
         WB_DAT_O     <= 32'h00000000;
         FETCH_ADDR   <= {BASE_W{1'b0}};
         FETCH_DW_MAX <= 12'h000;
         PIXEL_OFFSET <= 4'h0;
         LOCKED       <= 1'b0;
      end else begin
         WB_ACK_O <= req & adr_ok;
         WB_ERR_O <= req & ~adr_ok;
         LOCKED   <= lock_q;
         PIXEL_OFFSET <= fb_pend_q[3:0];
         case (WB_ADR_I)
            `GMO_FB_OFS:    WB_DAT_O <= {10'h000, fb_pend_q};
            `GMO_CB_OFS:    WB_DAT_O <= {10'h000, cb_q};
            `GMO_CUR_OFS:   WB_DAT_O <= {10'h000, cur_q};
            `GMO_LINE_OFS:  WB_DAT_O <= {4'h0, cb_dw_q, 4'h0, fb_dw_q};
            `GMO_PITCH_OFS: WB_DAT_O <= {4'h0, cb_pitch_q, 4'h0, fb_pitch_q};
            `GMO_LOCK_OFS:  WB_DAT_O <= {31'h00000000, lock_q};
            default:        WB_DAT_O <= 32'h00000000;
         endcase
         case (FETCH_SEL)
            SEL_FB: begin
               FETCH_ADDR   <= ap_addr(GFX_BASE, fb_line_q);
               FETCH_DW_MAX <= fb_dw_q;
            end
            SEL_CB: begin
               FETCH_ADDR   <= ap_addr(GFX_BASE, cb_line_q);
               FETCH_DW_MAX <= cb_dw_q;
            end
            SEL_CUR: begin
               FETCH_ADDR   <= ap_addr(GFX_BASE, cur_ptr_q);
               FETCH_DW_MAX <= 12'h000;
            end
            default: begin
               FETCH_ADDR   <= GFX_BASE;
               FETCH_DW_MAX <= 12'h000;
            end
         endcase
      end
   end
endmodule // gmo_core

// File: bench/gmo_fetch_model.sv
// Fetch engine stand-in: frame and line strobes.
// Assumes the bench pulses kick for one cycle per frame.
`timescale 1ns/100ps
module gmo_fetch_model (
   input  wire clk,
   input  wire rstn,
   input  wire kick,
   output reg  FRAME_START,
   output reg  LINE_START
);
   reg [2:0] cnt_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {cnt_q, FRAME_START, LINE_START} <= 5'h00;
      end else begin
         FRAME_START <= kick;
         LINE_START  <= (cnt_q == 3'h1);
         cnt_q       <= kick ? 3'h4 : cnt_q - {2'h0, |cnt_q};
      end
   end
endmodule // gmo_fetch_model

// File: bench/gmo_core_assertions.sv
// Port checks for the memory organization block.
// Assumes one clock with asynchronous active-low reset.
`timescale 1ns/100ps
`include "gmo_map.vh"
module gmo_core_assertions #(parameter BASE_W = 32) (
   input wire              SYS_CLK,
   input wire              RESETN,
   input wire              WB_CYC_I,
   input wire              WB_STB_I,
   input wire              WB_WE_I,
   input wire [15:0]       WB_ADR_I,
   input wire [31:0]       WB_DAT_I,
   input wire [31:0]       WB_DAT_O,
   input wire              WB_ACK_O,
   input wire              WB_ERR_O,
   input wire [BASE_W-1:0] GFX_BASE,
   input wire              FRAME_START,
   input wire [1:0]        FETCH_SEL,
   input wire [BASE_W-1:0] FETCH_ADDR,
   input wire [3:0]        PIXEL_OFFSET,
   input wire              LOCKED
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   wire tk  = WB_CYC_I & WB_STB_I & !WB_ACK_O & !WB_ERR_O;
   wire wfb = tk & WB_WE_I & (WB_ADR_I == `GMO_FB_OFS);
   property p_ans; tk |=> WB_ACK_O ^ WB_ERR_O; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_err; tk && (WB_ADR_I < `GMO_FB_OFS || WB_ADR_I > `GMO_LOCK_OFS) |=> WB_ERR_O; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_pix; wfb && !LOCKED |-> ##2 PIXEL_OFFSET == $past(WB_DAT_I[3:0], 2); endproperty
   a_pix: assert property (p_pix) else $error("pixel offset late");
   property p_lck; LOCKED |=> $stable(PIXEL_OFFSET); endproperty
   a_lck: assert property (p_lck) else $error("locked write applied");
   property p_rsv; tk && !WB_WE_I && WB_ADR_I == `GMO_FB_OFS |=> WB_DAT_O[31:22] == 10'h000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_frm; FRAME_START && FETCH_SEL == 2'h0 && $stable(GFX_BASE) |=> FETCH_ADDR[3:0] == $past(GFX_BASE[3:0]);
   endproperty
   a_frm: assert property (p_frm) else $error("pixel bits in address");
   property p_base; FETCH_SEL == 2'h3 && $stable(GFX_BASE) |=> FETCH_ADDR == $past(GFX_BASE); endproperty
   a_base: assert property (p_base) else $error("base not used");
   property p_key; tk && WB_WE_I && WB_ADR_I == `GMO_LOCK_OFS |-> ##2 LOCKED == ($past(WB_DAT_I, 2) != `GMO_LOCK_KEY);
   endproperty
   a_key: assert property (p_key) else $error("lock state wrong");
   c_frm: cover property (FRAME_START && FETCH_SEL == 2'h0);
   c_err: cover property (WB_ERR_O);
   c_lck: cover property ($rose(LOCKED));
endmodule // gmo_core_assertions
bind gmo_core gmo_core_assertions #(.BASE_W(BASE_W)) gmo_core_assertions_inst (.*);

// File: bench/gmo_core_test.sv
// Self-checking bench for the memory organization block.
// Assumes the fetch model makes frame and line strobes.
`timescale 1ns/100ps
`include "gmo_map.vh"
module gmo_core_test;
   reg         clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, kick = 1'b0, rerr, lk = 1'b0;
   reg  [15:0] adr = 16'h0000;
   reg  [31:0] wdat = 32'h0, base = 32'h0, rdat;
   reg  [1:0]  fsel = 2'h0;
   reg  [21:0] pend, live, fbv;
   reg  [11:0] pitch = 12'h040;
   wire [31:0] dat_o, faddr;
   wire [3:0]  pix;
   wire        ack, err, frm, lin, locked;
   integer     bad_count = 0, checked = 0, seed = 12, i;
   always #20 clk = ~clk;
   gmo_core gmo_core_inst (.SYS_CLK(clk), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err),
      .GFX_BASE(base), .FRAME_START(frm), .LINE_START(lin), .FETCH_SEL(fsel), .FETCH_ADDR(faddr),
      .FETCH_DW_MAX(), .PIXEL_OFFSET(pix), .LOCKED(locked));
   gmo_fetch_model gmo_fetch_model_inst (.clk(clk), .rstn(rstn), .kick(kick), .FRAME_START(frm), .LINE_START(lin));
   task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            $display("[ERR] %0s exp %h got %h", nm, e, g);
            bad_count = bad_count + 1;
         end
      end
   endtask
   task wb(input w, input [15:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk);
         {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
         n = 0;
         do begin @(posedge clk); n = n + 1; end while (!(ack | err) && n < 16);
         rdat = dat_o;
         rerr = err;
         {cyc, stb} <= 2'b00;
      end
   endtask
   // Writes the frame start, then checks pixel bits and readback against the model
   task fbw(input [21:0] x);
      begin
         wb(1'b1, `GMO_FB_OFS, {10'h000, x});
         if (!lk && x != 22'h0) pend = {x[21:4], 4'h0};
         if (!lk) fbv = x;
         @(negedge clk);
         chk("pix", {28'h0, fbv[3:0]}, {28'h0, pix});
         wb(1'b0, `GMO_FB_OFS, 32'h0);
         chk("rd", {10'h000, fbv}, rdat);
      end
   endtask
   task frame;
      begin
         @(posedge clk) kick <= 1'b1;
         @(posedge clk) kick <= 1'b0;
         live = pend;
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk("fetch", base + {10'h000, live + {10'h000, pitch}}, faddr);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      base <= $random(seed);
      wb(1'b1, `GMO_PITCH_OFS, {20'h0, pitch});
      wb(1'b1, `GMO_LINE_OFS, 32'h00500050);
      wb(1'b0, 16'h8400, 32'h0);
      chk("err", 32'h1, {31'h0, rerr});
      for (i = 0; i < 5; i = i + 1) begin
         fbw($random(seed));
         if (i > 0) chk("hold", base + {10'h000, live + {10'h000, pitch}}, faddr);
         frame;
      end
      @(posedge clk) fsel <= 2'h3;
      repeat (3) @(posedge clk);
      chk("base", base, faddr);
      fsel <= 2'h0;
      $display("test panning done");
      wb(1'b1, `GMO_LOCK_OFS, 32'h0);
      lk = 1'b1;
      @(negedge clk);
      chk("lock", 32'h1, {31'h0, locked});
      fbw(22'h3FFFF5);
      frame;
      wb(1'b1, `GMO_LOCK_OFS, `GMO_LOCK_KEY);
      lk = 1'b0;
      @(negedge clk);
      chk("unlock", 32'h0, {31'h0, locked});
      $display("test lock done");
      conclude;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      conclude;
   end
endmodule // gmo_core_test
